// ==== lpc_pkg.sv ====
// Summary of operation
// RULE_01 - four byte registers reached over serial bus
// RULE_02 - addresses 0..2 set pair A/B/C currents
// RULE_03 - address 3 switches each channel on/off
// RULE_04 - enable rising starts with zero current
// RULE_05 - enable low means shutdown, outputs high-impedance
// RULE_06 - undervoltage disables all six channels
// RULE_07 - sequence restarts in 1x, stays while regulating
// RULE_08 - regulation failure moves to 1.5x after 400us
// RULE_09 - restart on power-up, enable, mask write
// RULE_10 - all registers writable and readable, device acknowledges
// RULE_11 - host clears on/off bits of unfitted channels
// RULE_12 - respond only to bus address 1100110
// RULE_13 - read: address, pointer, restart, address, data, nack
// RULE_14 - current is half mA times code plus one
// RULE_15 - write: address, pointer, data; commit at byte end
// RULE_16 - 1.5x holds until next restart event
`default_nettype none
package lpc_pkg;

    // ----------------------------------------
    // bus addressing
    // ----------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h66; // fixed target address
    localparam logic [7:0] REG_COUNT = 8'h04; // pointers at or above read zero
    localparam logic [1:0] REG_PAIR_A = 2'h0; // pair A current code
    localparam logic [1:0] REG_PAIR_B = 2'h1; // pair B current code
    localparam logic [1:0] REG_PAIR_C = 2'h2; // pair C current code
    localparam logic [1:0] REG_MASK = 2'h3; // channel on/off mask

    // ----------------------------------------
    // field layout and reset values
    // ----------------------------------------
    localparam int CODE_W = 6; // bits 5:0 used, 7:6 unused
    localparam logic [5:0] CODE_RESET = 6'h00; // zero in every register
    localparam logic [1:0] UNUSED_READ = 2'h0; // bits 7:6 read back
    localparam logic [3:0] LAST_DATA_BIT = 4'h7; // eighth bit of a byte
    localparam logic [3:0] ACK_SLOT = 4'h8; // ninth clock of a byte

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 125; // system clock rate
    localparam int FALLBACK_US = 400; // 1x failure time before 1.5x
    localparam int FALLBACK_CYCLES = FALLBACK_US * CLK_MHZ;
    localparam int TIMER_W = 16; // fallback timer width

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic chan_c_second; // bit 5
        logic chan_c_first; // bit 4
        logic chan_b_second; // bit 3
        logic chan_b_first; // bit 2
        logic chan_a_second; // bit 1
        logic chan_a_first; // bit 0
    } lpc_chan_t;

    typedef struct packed {
        logic [CODE_W-1:0] pair_c; // channels c first/second
        logic [CODE_W-1:0] pair_b; // channels b first/second
        logic [CODE_W-1:0] pair_a; // channels a first/second
    } lpc_codes_t;

    typedef enum logic [2:0] {
        LK_ADDR, LK_PTR, LK_WDATA, LK_RDATA, LK_IDLE
    } lpc_link_t;

    typedef enum logic [1:0] {
        PUMP_OFF, PUMP_1X, PUMP_WAIT, PUMP_BOOST
    } lpc_pump_t;

endpackage
`default_nettype wire

// ==== lpc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module lpc_top #(
    parameter int unsigned FALLBACK_CYCLES = lpc_pkg::FALLBACK_CYCLES
) (
    input wire logic clock, // system clock, 125 MHz
    input wire logic resetn, // async reset, active low
    input wire logic scl, // serial bus clock
    input wire logic sda_in, // serial data level seen
    output logic sda_out, // data driven when enabled
    output logic sda_oe_n, // low while pulling data low
    input wire logic enable, // enable pin, low = shutdown
    input wire logic supply_undervoltage_flag, // supply too low
    input wire logic regulation_ok, // enabled channels regulate
    output lpc_pkg::lpc_chan_t chan_drive, // per-channel sink on
    output wire lpc_pkg::lpc_codes_t pair_codes, // current codes
    output logic outputs_hiz, // shutdown, sinks floating
    output logic pump_boost // 1 = 1.5x, 0 = 1x
);

    // ----------------------------------------
    // system domain declarations
    // ----------------------------------------
    logic [4:0] pin_s1; // first sync stage
    logic [4:0] pin_s2; // second sync stage
    logic [1:0] pin_s3; // scl/sda history for edges
    logic active; // enable seen high
    logic uv_seen; // undervoltage synced
    logic reg_ok_seen; // regulation synced
    logic bus_start; // data falls while clock high
    logic bus_stop; // data rises while clock high
    logic link_rst; // holds link logic idle
    logic shadow_rst; // clears link register copy
    logic [2:0] tgl_sync; // write toggle sync + history
    logic wr_evt; // one write committed
    logic [lpc_pkg::CODE_W-1:0] regs [4]; // register bank
    lpc_pkg::lpc_pump_t pump_st; // pump mode sequencer
    logic [lpc_pkg::TIMER_W-1:0] fail_cnt; // 1x failure timer
    logic restart; // mask write restarts sequence

    // ----------------------------------------
    // link domain declarations
    // ----------------------------------------
    lpc_pkg::lpc_link_t link_st; // byte role in frame
    logic [3:0] bit_cnt; // 0..7 data, 8 ack slot
    logic [6:0] shift; // bits received so far
    logic [7:0] rx_byte; // byte completed this edge
    logic ack_now; // acknowledge this byte
    logic [7:0] ptr; // register pointer
    logic [lpc_pkg::CODE_W-1:0] shadow [4]; // link copy
    logic [7:0] tx_byte; // byte served on a read
    logic [1:0] wr_addr; // held address of last write
    logic [lpc_pkg::CODE_W-1:0] wr_data; // held data
    logic wr_tgl; // flips once per write

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // order: scl, sda, enable, undervoltage, regulation
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_s1 <= 5'h00;
            pin_s2 <= 5'h00;
            pin_s3 <= 2'h0;
        end else begin
            pin_s1 <= {scl, sda_in, enable,
                       supply_undervoltage_flag, regulation_ok};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2[4:3];
        end
    end

    assign active = pin_s2[2];
    assign uv_seen = pin_s2[1];
    assign reg_ok_seen = pin_s2[0];

    // start and stop seen from the synced levels
    assign bus_start = pin_s2[4] & pin_s3[1] & pin_s3[0] & ~pin_s2[3];
    assign bus_stop = pin_s2[4] & pin_s3[1] & ~pin_s3[0] & pin_s2[3];

    // ----------------------------------------
    // link resets from the system side
    // ----------------------------------------
    // start/stop reframe the link; release only once scl is low
    // so the link side never sees an edge near the release
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link_rst <= 1'b1;
        end else if (!active || bus_start || bus_stop) begin
            link_rst <= 1'b1; // RULE_05
        end else if (!pin_s2[4]) begin
            link_rst <= 1'b0;
        end
    end

    // shutdown forgets every setting
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shadow_rst <= 1'b1;
        end else begin
            shadow_rst <= ~active; // RULE_04
        end
    end

    // ----------------------------------------
    // link: byte framing and acknowledge
    // ----------------------------------------
    // data is sampled on the rising scl edge; the master holds
    // it stable around that edge, so no extra sync is needed
    assign rx_byte = {shift, sda_in};

    always_ff @(posedge scl or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt <= 4'h0;
            shift <= 7'h00;
        end else begin
            // count nine clocks per byte
            if (bit_cnt == lpc_pkg::ACK_SLOT) begin
                bit_cnt <= 4'h0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                shift <= rx_byte[6:0];
            end
        end
    end

    // role of each byte within the frame
    always_ff @(posedge scl or posedge link_rst) begin
        if (link_rst) begin
            link_st <= lpc_pkg::LK_ADDR;
            ack_now <= 1'b0;
        end else if (bit_cnt == lpc_pkg::LAST_DATA_BIT) begin
            ack_now <= 1'b0;
            unique case (link_st)
                // address byte: match or drop out
                lpc_pkg::LK_ADDR: begin
                    if (rx_byte[7:1] == lpc_pkg::DEV_ADDR) begin // RULE_12
                        ack_now <= 1'b1; // RULE_10
                        if (rx_byte[0]) begin
                            link_st <= lpc_pkg::LK_RDATA; // RULE_13
                        end else begin
                            link_st <= lpc_pkg::LK_PTR; // RULE_15
                        end
                    end else begin
                        link_st <= lpc_pkg::LK_IDLE;
                    end
                end
                // pointer byte always accepted
                lpc_pkg::LK_PTR: begin
                    ack_now <= 1'b1; // RULE_15
                    link_st <= lpc_pkg::LK_WDATA;
                end
                // data bytes accepted, same register
                lpc_pkg::LK_WDATA: begin
                    ack_now <= 1'b1; // RULE_15
                end
                // master acknowledges read bytes
                lpc_pkg::LK_RDATA: begin
                    ack_now <= 1'b0;
                end
                lpc_pkg::LK_IDLE: begin
                    ack_now <= 1'b0;
                end
                default: begin
                    link_st <= lpc_pkg::LK_IDLE;
                end
            endcase
        end else if (bit_cnt == lpc_pkg::ACK_SLOT
                     && link_st == lpc_pkg::LK_RDATA && sda_in) begin
            // not-acknowledge ends the read
            link_st <= lpc_pkg::LK_IDLE; // RULE_13
        end
    end

    // ----------------------------------------
    // link: pointer, register copy, write hand-off
    // ----------------------------------------
    // survives repeated start; cleared only by shutdown/reset
    always_ff @(posedge scl or posedge shadow_rst) begin
        if (shadow_rst) begin
            ptr <= 8'h00;
            wr_addr <= 2'h0;
            wr_data <= lpc_pkg::CODE_RESET;
            wr_tgl <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                shadow[i] <= lpc_pkg::CODE_RESET;
            end
        end else if (bit_cnt == lpc_pkg::LAST_DATA_BIT) begin
            if (link_st == lpc_pkg::LK_PTR) begin
                ptr <= rx_byte;
            end else if (link_st == lpc_pkg::LK_WDATA
                         && ptr < lpc_pkg::REG_COUNT) begin
                // bits 7:6 are dropped
                shadow[ptr[1:0]] <= rx_byte[5:0]; // RULE_02
                wr_addr <= ptr[1:0];
                wr_data <= rx_byte[5:0];
                wr_tgl <= ~wr_tgl; // RULE_15
            end
        end
    end

    // read value served from the link-side copy
    assign tx_byte = (ptr < lpc_pkg::REG_COUNT)
                   ? {lpc_pkg::UNUSED_READ, shadow[ptr[1:0]]}
                   : 8'h00; // RULE_10

    // ----------------------------------------
    // link: data line driver
    // ----------------------------------------
    // changes only after scl falls, so data is stable while high
    always_ff @(negedge scl or posedge link_rst) begin
        if (link_rst) begin
            sda_oe_n <= 1'b1;
        end else if (bit_cnt == lpc_pkg::ACK_SLOT) begin
            sda_oe_n <= ~ack_now; // RULE_10
        end else if (link_st == lpc_pkg::LK_RDATA) begin
            // msb first; a one releases the line
            sda_oe_n <= tx_byte[3'(lpc_pkg::LAST_DATA_BIT - bit_cnt)]; // RULE_13
        end else begin
            sda_oe_n <= 1'b1;
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // write commit into the system domain
    // ----------------------------------------
    // address and data stay held for a whole byte after the
    // toggle, far longer than the sync delay
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tgl_sync <= 3'h0;
        end else if (!active) begin
            tgl_sync <= 3'h0;
        end else begin
            tgl_sync <= {tgl_sync[1:0], wr_tgl};
        end
    end

    assign wr_evt = tgl_sync[1] ^ tgl_sync[2];
    assign restart = wr_evt && wr_addr == lpc_pkg::REG_MASK;

    // register bank
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                regs[i] <= lpc_pkg::CODE_RESET;
            end
        end else if (!active) begin
            // shutdown clears: next enable starts at zero current
            for (int i = 0; i < 4; i++) begin
                regs[i] <= lpc_pkg::CODE_RESET; // RULE_04
            end
        end else if (wr_evt) begin
            regs[wr_addr] <= wr_data; // RULE_01
        end
    end

    // codes go to the current DACs: 0.5 mA x (code + 1)
    assign pair_codes = {regs[lpc_pkg::REG_PAIR_C],
                         regs[lpc_pkg::REG_PAIR_B],
                         regs[lpc_pkg::REG_PAIR_A]}; // RULE_14

    // ----------------------------------------
    // channel gating
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chan_drive <= lpc_pkg::lpc_chan_t'(6'h00);
            outputs_hiz <= 1'b1;
        end else begin
            outputs_hiz <= ~active; // RULE_05
            if (!active || uv_seen) begin
                chan_drive <= lpc_pkg::lpc_chan_t'(6'h00); // RULE_06
            end else begin
                chan_drive <= lpc_pkg::lpc_chan_t'(regs[lpc_pkg::REG_MASK]); // RULE_03
            end
        end
    end

    // ----------------------------------------
    // charge pump mode sequencer
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pump_st <= lpc_pkg::PUMP_OFF; // RULE_09
            fail_cnt <= '0;
        end else if (!active) begin
            pump_st <= lpc_pkg::PUMP_OFF;
            fail_cnt <= '0;
        end else if (restart) begin
            pump_st <= lpc_pkg::PUMP_1X; // RULE_09
            fail_cnt <= '0;
        end else begin
            unique case (pump_st)
                // leaving shutdown or reset
                lpc_pkg::PUMP_OFF: begin
                    pump_st <= lpc_pkg::PUMP_1X; // RULE_09
                end
                // efficient mode while regulating
                lpc_pkg::PUMP_1X: begin
                    fail_cnt <= '0;
                    if (!reg_ok_seen) begin
                        pump_st <= lpc_pkg::PUMP_WAIT; // RULE_07
                    end
                end
                // failure must persist the whole delay
                lpc_pkg::PUMP_WAIT: begin
                    if (reg_ok_seen) begin
                        pump_st <= lpc_pkg::PUMP_1X; // RULE_07
                    end else if (fail_cnt
                                 == lpc_pkg::TIMER_W'(FALLBACK_CYCLES - 1)) begin
                        pump_st <= lpc_pkg::PUMP_BOOST; // RULE_08
                    end else begin
                        fail_cnt <= fail_cnt + 1'b1;
                    end
                end
                // held until a restart event
                lpc_pkg::PUMP_BOOST: begin
                    pump_st <= lpc_pkg::PUMP_BOOST; // RULE_16
                end
            endcase
        end
    end

    // mode output
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pump_boost <= 1'b0;
        end else begin
            pump_boost <= (pump_st == lpc_pkg::PUMP_BOOST); // RULE_08
        end
    end

endmodule
`default_nettype wire

// ==== lpc_top_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module lpc_top_chk #(
    parameter int unsigned FALLBACK_CYCLES = 20
) (
    input wire logic clock, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic scl, // bus clock
    input wire logic sda_in, // data level seen
    input wire logic sda_out, // data driven when enabled
    input wire logic sda_oe_n, // low while pulling data
    input wire logic enable, // low = shutdown
    input wire logic supply_undervoltage_flag, // supply too low
    input wire logic regulation_ok, // channels regulate
    input wire lpc_pkg::lpc_chan_t chan_drive, // sinks on
    input wire lpc_pkg::lpc_codes_t pair_codes, // current codes
    input wire logic outputs_hiz, // sinks floating
    input wire logic pump_boost // 1.5x mode
);
    // ----------------------------------------
    // helper: run of failing regulation while enabled
    // ----------------------------------------
    int unsigned fail_cnt; // consecutive failing clocks
    // cleared on recovery or shutdown, saturates past the window
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fail_cnt <= 0;
        end else if (regulation_ok || !enable) begin
            fail_cnt <= 0;
        end else if (fail_cnt <= FALLBACK_CYCLES + 20) begin
            fail_cnt <= fail_cnt + 1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_shut; !enable [*5]; endsequence // settled shutdown
    sequence s_awake; enable [*5]; endsequence // settled active
    sequence s_uv; supply_undervoltage_flag [*5]; endsequence // settled low supply
    sda_low_only_a: assert property (sda_out == 1'b0)
        else $error("data driven high");
    shut_hiz_a: assert property (s_shut |-> outputs_hiz)
        else $error("sinks not floating in shutdown");
    shut_clear_a: assert property (s_shut |-> !{pair_codes, chan_drive, pump_boost})
        else $error("state kept in shutdown");
    shut_no_ack_a: assert property (s_shut |-> sda_oe_n)
        else $error("bus answered in shutdown");
    awake_drive_a: assert property (s_awake |-> !outputs_hiz)
        else $error("still floating when enabled");
    uv_off_a: assert property (s_uv |-> chan_drive == '0)
        else $error("channels on in undervoltage");
    boost_early_a: assert property ($rose(pump_boost) |-> fail_cnt >= FALLBACK_CYCLES)
        else $error("boost before fallback time");
    boost_late_a: assert property (fail_cnt == FALLBACK_CYCLES + 10 |-> pump_boost)
        else $error("boost missing after fallback time");
    hiz_dark_a: assert property (outputs_hiz [*3] |-> chan_drive == '0)
        else $error("sinks on while floating");
    oe_scl_low_a: assert property ($changed(sda_oe_n) |-> !scl)
        else $error("data changed with clock high");
endmodule
`default_nettype wire

// ==== lpc_i2c_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module lpc_i2c_master (
    output logic scl, // bus clock, high when idle
    output logic sda_drv, // 0 pulls data low, 1 releases
    input wire logic sda // resolved data level
);
    // ----------------------------------------
    // bit level, 64 ns per bit, clock still between frames
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // data set mid low phase, held over the high phase
    task automatic bit_o(input logic b);
        sda_drv = b;
        #16 scl = 1'b1;
        #32 scl = 1'b0;
        #16;
    endtask
    // line released, sampled mid high phase
    task automatic bit_i(output logic b);
        sda_drv = 1'b1;
        #16 scl = 1'b1;
        #16 b = sda;
        #16 scl = 1'b0;
        #16;
    endtask
    // start or repeated start; odd offset keeps phase unrelated
    task automatic start();
        #3 sda_drv = 1'b1;
        #16 scl = 1'b1;
        #32 sda_drv = 1'b0;
        #32 scl = 1'b0;
        #16;
    endtask
    // stop, then bus free time
    task automatic stop();
        sda_drv = 1'b0;
        #16 scl = 1'b1;
        #32 sda_drv = 1'b1;
        #64;
    endtask
    // ----------------------------------------
    // byte level, msb first
    // ----------------------------------------
    task automatic byte_o(input logic [7:0] d, output logic ack);
        logic nak; // ninth bit from the device
        for (int i = 7; i >= 0; i--) begin
            bit_o(d[i]);
        end
        bit_i(nak);
        ack = !nak;
    endtask
    task automatic byte_i(output logic [7:0] d, input logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_i(d[i]);
        end
        bit_o(nak);
    endtask
    // ----------------------------------------
    // frames, always started by this side
    // ----------------------------------------
    // start, address+write, pointer, data, stop
    task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic [2:0] ack);
        start();
        byte_o({a, 1'b0}, ack[2]);
        byte_o(p, ack[1]);
        byte_o(d, ack[0]);
        stop();
    endtask
    // pointer write, repeated start, one byte back, nack, stop
    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic [2:0] ack);
        start();
        byte_o({lpc_pkg::DEV_ADDR, 1'b0}, ack[2]);
        byte_o(p, ack[1]);
        start();
        byte_o({lpc_pkg::DEV_ADDR, 1'b1}, ack[0]);
        byte_i(d, 1'b1);
        stop();
    endtask
endmodule
`default_nettype wire

// ==== lpc_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module lpc_top_tb_top;
    localparam int unsigned FB = 20; // shortened fallback count
    localparam logic [6:0] DA = lpc_pkg::DEV_ADDR; // own address
    logic clock, resetn, enable, supply_undervoltage_flag, regulation_ok; // inputs
    wire logic scl, sda_drv, sda_out, sda_oe_n, outputs_hiz, pump_boost; // bus and flags
    wire lpc_pkg::lpc_chan_t chan_drive; // sinks on
    wire lpc_pkg::lpc_codes_t pair_codes; // current codes
    wire logic sda = sda_drv & (sda_oe_n | sda_out); // pulled-up data line
    int err_count, samples_checked; // tallies
    logic [2:0] ack; // acks of one frame
    logic [7:0] rdat; // byte read back
    lpc_top #(.FALLBACK_CYCLES(FB)) i_dut (.clock(clock), .resetn(resetn), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .enable(enable),
        .supply_undervoltage_flag(supply_undervoltage_flag), .regulation_ok(regulation_ok),
        .chan_drive(chan_drive), .pair_codes(pair_codes), .outputs_hiz(outputs_hiz),
        .pump_boost(pump_boost));
    lpc_i2c_master i_master (.scl(scl), .sda_drv(sda_drv), .sda(sda));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic [17:0] seen, exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // shutdown after reset, then wake with zero current
    task automatic t_reset();
        chk(18'(outputs_hiz), 18'h00001, "not floating in shutdown");
        enable <= 1'b1;
        cyc(10);
        chk(18'(outputs_hiz), 18'h00000, "still floating");
        chk(pair_codes, 18'h00000, "codes not zero on wake");
        i_master.rd(8'h03, rdat, ack);
        chk(18'(rdat), 18'h00000, "mask not zero on wake");
        $display("test reset done");
    endtask
    // every register written then read back, plus an unmapped pointer
    task automatic t_regs();
        logic [7:0] v [4]; // written values, each with bit 7 or bit 6 set
        v = '{8'hFF, 8'h40, 8'h95, 8'hE5};
        for (int i = 0; i < 5; i++) begin
            i_master.wr(DA, 8'(i), (i < 4) ? v[i] : 8'h2A, ack);
            chk(18'(ack), 18'h00007, "write not acked");
            i_master.rd(8'(i), rdat, ack);
            chk(18'(ack), 18'h00007, "read not acked");
            chk(18'(rdat), (i < 4) ? 18'(v[i] & 8'h3F) : 18'h00000, "read back");
        end
        chk(pair_codes, {v[2][5:0], v[1][5:0], v[0][5:0]}, "pair codes");
        chk(18'(chan_drive), 18'h00025, "channel map");
        $display("test regs done");
    endtask
    // foreign addresses get no answer and change nothing
    task automatic t_addr();
        logic [6:0] bad [2]; // near misses in low and high bit
        bad = '{7'h67, 7'h26};
        for (int i = 0; i < 2; i++) begin
            i_master.wr(bad[i], 8'h00, 8'h01, ack);
            chk(18'(ack), 18'h00000, "foreign address acked");
        end
        chk(18'(pair_codes[5:0]), 18'h0003F, "foreign write landed");
        $display("test addr done");
    endtask
    // undervoltage darkens all channels, recovery restores the mask
    task automatic t_uv();
        @(negedge clock) supply_undervoltage_flag <= 1'b1;
        cyc(8);
        chk(18'(chan_drive), 18'h00000, "on in undervoltage");
        supply_undervoltage_flag <= 1'b0;
        cyc(8);
        chk(18'(chan_drive), 18'h00025, "not restored");
        $display("test uv done");
    endtask
    // fallback timing, hold in 1.5x, restart on mask write
    task automatic t_pump();
        regulation_ok <= 1'b0;
        cyc(FB);
        chk(18'(pump_boost), 18'h00000, "boost too early");
        cyc(12);
        chk(18'(pump_boost), 18'h00001, "no boost");
        regulation_ok <= 1'b1;
        cyc(10);
        chk(18'(pump_boost), 18'h00001, "boost dropped");
        i_master.wr(DA, 8'h03, 8'h0F, ack);
        cyc(6);
        chk(18'(pump_boost), 18'h00000, "mask write kept boost");
        chk(18'(chan_drive), 18'h0000F, "four channels");
        for (int i = 0; i < 2; i++) begin
            regulation_ok <= 1'b0;
            cyc(FB / 2);
            regulation_ok <= 1'b1;
            cyc(1);
        end
        cyc(8);
        chk(18'(pump_boost), 18'h00000, "broken failure boosted");
        $display("test pump done");
    endtask
    // shutdown from 1.5x, bus ignored, wake cleared in 1x
    task automatic t_shut();
        regulation_ok <= 1'b0;
        cyc(FB + 12);
        chk(18'(pump_boost), 18'h00001, "no boost");
        enable <= 1'b0;
        cyc(6);
        chk({17'h00000, outputs_hiz}, 18'h00001, "not floating");
        i_master.wr(DA, 8'h00, 8'h11, ack);
        chk(18'(ack), 18'h00000, "acked in shutdown");
        @(negedge clock) regulation_ok <= 1'b1;
        enable <= 1'b1;
        cyc(10);
        chk(18'(pump_boost), 18'h00000, "wake kept boost");
        chk(pair_codes, 18'h00000, "codes kept");
        chk(18'(chan_drive), 18'h00000, "mask kept");
        $display("test shut done");
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        err_count = 0;
        samples_checked = 0;
        resetn = 1'b0;
        enable = 1'b0;
        supply_undervoltage_flag = 1'b0;
        regulation_ok = 1'b1;
        repeat (4) @(posedge clock);
        @(negedge clock) resetn <= 1'b1;
        cyc(2);
        t_reset();
        t_regs();
        t_addr();
        t_uv();
        t_pump();
        t_shut();
        final_report();
    end
    initial begin
        #400000;
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        final_report();
    end
endmodule
bind lpc_top lpc_top_chk #(.FALLBACK_CYCLES(FALLBACK_CYCLES)) i_chk (.clock(clock),
    .resetn(resetn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .enable(enable), .supply_undervoltage_flag(supply_undervoltage_flag),
    .regulation_ok(regulation_ok), .chan_drive(chan_drive), .pair_codes(pair_codes),
    .outputs_hiz(outputs_hiz), .pump_boost(pump_boost));
`default_nettype wire
